/* hdl/autoneg_partner_status_regs.sv */
// Purpose: partner ability and expansion status registers behind AXI4-Lite
// Assumes: negotiation state machine runs on SYS_CLK; AXI master on SYS_CLK
// Notes:   one read and one write in flight; read clears the page flag
//
// Operation
// - ability word loaded from partner, read-only
// - ability may change after completion with next pages
// - bit 15 shows partner next-page request
// - bit 14 shows partner acknowledge from bursts
// - bit 13 shows partner remote fault
// - bits 11, 10 show partner pause abilities
// - bits 9 to 5 show partner technologies
// - bits 4 to 0 hold selector, reset zero
// - reserved bit 12 always reads zero
// - expansion bits 15 to 5 read zero
// - expansion bit 4 shows parallel detect fault
// - expansion bit 3 shows partner next-page ability
// - expansion bit 2 local next-page, default one
// - expansion bit 1 page received, clear on read
// - expansion bit 0 partner negotiation ability
`timescale 1ns/100ps
`include "autoneg_partner_status_params.svh"

module autoneg_partner_status_regs (
  input  wire logic                                SYS_CLK,
  input  wire logic                                RST_N,
  input  wire logic [7:0]                          S_AWADDR,
  input  wire logic                                S_AWVALID,
  output logic                                     S_AWREADY,
  input  wire logic [31:0]                         S_WDATA,
  input  wire logic [3:0]                          S_WSTRB,
  input  wire logic                                S_WVALID,
  output logic                                     S_WREADY,
  output logic [1:0]                               S_BRESP,
  output logic                                     S_BVALID,
  input  wire logic                                S_BREADY,
  input  wire logic [7:0]                          S_ARADDR,
  input  wire logic                                S_ARVALID,
  output logic                                     S_ARREADY,
  output logic [31:0]                              S_RDATA,
  output logic [1:0]                               S_RRESP,
  output logic                                     S_RVALID,
  input  wire logic                                S_RREADY,
  input  wire autoneg_partner_status_pkg::an_event_type AN_EVENTS,
  output logic                                     IRQ
);

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  // byte address of a register index
  function automatic logic [7:0] byte_addr(input logic [5:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  // true when a bus address hits the given register
  function automatic logic hits(input logic [7:0] addr, input logic [5:0] idx);
    hits = (addr == byte_addr(idx));
  endfunction : hits

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  autoneg_partner_status_pkg::ability_word_type partner_base_page_ability;
  logic        parallel_detect_fault;
  logic        local_next_page_capable;
  logic        page_received;
  logic        partner_autoneg_capable;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic        fault_prev;
  logic        an_detect_prev;
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // --------------------------------------------------------------------------
  // write channel: address and data taken in either order
  // --------------------------------------------------------------------------
  wire         aw_take   = S_AWVALID & S_AWREADY;
  wire         w_take    = S_WVALID & S_WREADY;
  wire         do_write  = aw_held & w_held & ~S_BVALID;
  wire         wr_low    = do_write & w_strb[0];
  wire         wr_status = wr_low & hits(aw_addr, `APS_IDX_IRQ_STATUS);
  wire         wr_mask   = wr_low & hits(aw_addr, `APS_IDX_IRQ_MASK);
  wire         soft_reset = wr_low & hits(aw_addr, `APS_IDX_CONTROL)
                            & w_data[`APS_CTRL_SOFT_RESET];
  wire         wr_mapped = hits(aw_addr, `APS_IDX_PARTNER_ABILITY)
                           | hits(aw_addr, `APS_IDX_EXPANSION)
                           | hits(aw_addr, `APS_IDX_IRQ_STATUS)
                           | hits(aw_addr, `APS_IDX_IRQ_MASK)
                           | hits(aw_addr, `APS_IDX_CONTROL);

  assign S_AWREADY = ~aw_held & ~S_BVALID;
  assign S_WREADY  = ~w_held & ~S_BVALID;

  // hold address and data until both are present
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= S_AWADDR;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= S_WDATA;
        w_strb <= S_WSTRB;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_BVALID <= 1'b0;
      S_BRESP  <= `APS_RESP_OKAY;
    end else if (do_write) begin
      S_BVALID <= 1'b1;
      S_BRESP  <= wr_mapped ? `APS_RESP_OKAY : `APS_RESP_SLVERR;
    end else if (S_BREADY) begin
      S_BVALID <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  wire        ar_take  = S_ARVALID & S_ARREADY;
  wire        rd_exp   = ar_take & hits(S_ARADDR, `APS_IDX_EXPANSION);
  wire [15:0] exp_word = {11'h000,
                          parallel_detect_fault,
                          partner_base_page_ability.partner_next_page_request,
                          local_next_page_capable,
                          page_received,
                          partner_autoneg_capable};
  wire        rd_hit_abil = hits(S_ARADDR, `APS_IDX_PARTNER_ABILITY);
  wire        rd_hit_exp  = hits(S_ARADDR, `APS_IDX_EXPANSION);
  wire        rd_hit_st   = hits(S_ARADDR, `APS_IDX_IRQ_STATUS);
  wire        rd_hit_mask = hits(S_ARADDR, `APS_IDX_IRQ_MASK);
  wire        rd_hit_ctrl = hits(S_ARADDR, `APS_IDX_CONTROL);
  wire        rd_mapped   = rd_hit_abil | rd_hit_exp | rd_hit_st | rd_hit_mask | rd_hit_ctrl;
  wire [31:0] rd_word     = rd_hit_abil ? {16'h0000, partner_base_page_ability} :
                            rd_hit_exp  ? {16'h0000, exp_word} :
                            rd_hit_st   ? {29'h00000000, irq_status} :
                            rd_hit_mask ? {29'h00000000, irq_mask} :
                                          32'h00000000;

  assign S_ARREADY = ~S_RVALID;

  // data is registered; answer stands until rready
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_RVALID <= 1'b0;
      S_RDATA  <= 32'h00000000;
      S_RRESP  <= `APS_RESP_OKAY;
    end else if (ar_take) begin
      S_RVALID <= 1'b1;
      S_RDATA  <= rd_word;
      S_RRESP  <= rd_mapped ? `APS_RESP_OKAY : `APS_RESP_SLVERR;
    end else if (S_RREADY) begin
      S_RVALID <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // partner ability capture
  // --------------------------------------------------------------------------
  // after completion only a next-page exchange may overwrite the base word
  wire allow_load = ~AN_EVENTS.an_complete
                    | (local_next_page_capable
                       & partner_base_page_ability.partner_next_page_request);
  wire load_page  = AN_EVENTS.page_valid & allow_load;
  autoneg_partner_status_pkg::ability_word_type next_ability;
  always_comb begin
    next_ability          = AN_EVENTS.page_word;
    next_ability.reserved = 1'b0;
  end

  // bus writes reach this word only through the control soft reset; a received page in the same cycle wins over it
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      partner_base_page_ability <= `APS_RST_ABILITY;
    end else if (load_page) begin
      partner_base_page_ability <= next_ability;
    end else if (soft_reset) begin
      partner_base_page_ability <= `APS_RST_ABILITY;
    end
  end

  // --------------------------------------------------------------------------
  // expansion flags
  // --------------------------------------------------------------------------
  // page flag: a new page in the same cycle as the clearing read wins
  wire next_page_received = AN_EVENTS.page_valid
                            | (page_received & ~rd_exp & ~soft_reset);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      parallel_detect_fault   <= 1'b0;
      page_received           <= 1'b0;
      partner_autoneg_capable <= 1'b0;
      local_next_page_capable <= `APS_RST_LOCAL_NP;
    end else begin
      parallel_detect_fault   <= AN_EVENTS.parallel_fault;
      page_received           <= next_page_received;
      partner_autoneg_capable <= AN_EVENTS.partner_an_detect;
    end
  end

  // --------------------------------------------------------------------------
  // interrupts: sticky status, write one to clear, mask gates the output
  // --------------------------------------------------------------------------
  wire [2:0] irq_events;
  assign irq_events[`APS_IRQ_PAGE]       = AN_EVENTS.page_valid;
  assign irq_events[`APS_IRQ_FAULT]      = AN_EVENTS.parallel_fault & ~fault_prev;
  assign irq_events[`APS_IRQ_PARTNER_AN] = AN_EVENTS.partner_an_detect & ~an_detect_prev;
  wire [2:0] irq_clear  = wr_status ? w_data[2:0] : 3'h0;
  wire [2:0] next_irq_status = irq_events | (irq_status & ~irq_clear);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_status     <= `APS_RST_IRQ;
      irq_mask       <= `APS_RST_IRQ;
      fault_prev     <= 1'b0;
      an_detect_prev <= 1'b0;
    end else begin
      irq_status     <= next_irq_status;
      fault_prev     <= AN_EVENTS.parallel_fault;
      an_detect_prev <= AN_EVENTS.partner_an_detect;
      if (wr_mask) begin
        irq_mask <= w_data[2:0];
      end
    end
  end

  assign IRQ = |(irq_status & irq_mask);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking chk_clk @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  ability_load_a: assert property (load_page |=> partner_base_page_ability ==
      {$past(AN_EVENTS.page_word[15:13]), 1'b0, $past(AN_EVENTS.page_word[11:0])})
    else $error("ability word not loaded from received page");
  ability_hold_a: assert property (AN_EVENTS.page_valid & AN_EVENTS.an_complete
      & ~partner_base_page_ability.partner_next_page_request & ~soft_reset
      |=> $stable(partner_base_page_ability))
    else $error("base page changed after completion without next pages");
  reserved_zero_a: assert property (partner_base_page_ability.reserved == 1'b0)
    else $error("reserved ability bit set");
  exp_upper_zero_a: assert property (rd_exp |=> S_RDATA[31:5] == 27'h0000000)
    else $error("expansion upper bits not zero");
  fault_follow_a: assert property (AN_EVENTS.parallel_fault |=> parallel_detect_fault)
    else $error("parallel fault not reported");
  lp_np_read_a: assert property (rd_exp |=> S_RDATA[`APS_EXP_LP_NP] ==
      $past(partner_base_page_ability.partner_next_page_request))
    else $error("partner next page bit wrong");
  local_np_a: assert property (local_next_page_capable)
    else $error("local next page flag lost");
  page_set_a: assert property (AN_EVENTS.page_valid |=> page_received [*1])
    else $error("page flag not set");
  page_cor_a: assert property (rd_exp & ~AN_EVENTS.page_valid
      |=> S_RDATA[`APS_EXP_PAGE_RX] == $past(page_received) && !page_received)
    else $error("page flag not cleared by read");
  an_able_a: assert property (AN_EVENTS.partner_an_detect ##1 1'b1
      |-> partner_autoneg_capable)
    else $error("partner negotiation ability not shown");
  ro_write_a: assert property (do_write & ~AN_EVENTS.page_valid & ~soft_reset
      |=> $stable(partner_base_page_ability))
    else $error("write changed the ability word");
  reset_val_a: assert property ($rose(RST_N) |-> partner_base_page_ability == 16'h0000
      && !page_received && local_next_page_capable)
    else $error("bad value after reset");
  read_lat_a: assert property (ar_take |=> S_RVALID)
    else $error("read answer late");
  irq_level_a: assert property (IRQ == |(irq_status & irq_mask))
    else $error("interrupt level wrong");

  page_read_c:  cover property (AN_EVENTS.page_valid ##[1:20] rd_exp);
  race_c:       cover property (AN_EVENTS.page_valid & rd_exp);
  late_page_c:  cover property (AN_EVENTS.page_valid & AN_EVENTS.an_complete & allow_load);
  irq_c:        cover property ($rose(IRQ));

endmodule : autoneg_partner_status_regs

/* hdl/autoneg_partner_status_params.svh */
// Purpose: offsets, field positions, reset values of the partner status registers
// Assumes: included by bare name wherever a constant is needed
// Notes:   register indices are word numbers; byte address is four times the index
`ifndef AUTONEG_PARTNER_STATUS_PARAMS_SVH
`define AUTONEG_PARTNER_STATUS_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------------
`define APS_IDX_PARTNER_ABILITY  6'h05
`define APS_IDX_EXPANSION        6'h06
`define APS_IDX_IRQ_STATUS       6'h10
`define APS_IDX_IRQ_MASK         6'h11
`define APS_IDX_CONTROL          6'h12

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define APS_ABIL_NEXT_PAGE       15
`define APS_ABIL_RESERVED        12
`define APS_EXP_PDF              4
`define APS_EXP_LP_NP            3
`define APS_EXP_LOCAL_NP         2
`define APS_EXP_PAGE_RX          1
`define APS_EXP_LP_AN            0
`define APS_IRQ_PAGE             0
`define APS_IRQ_FAULT            1
`define APS_IRQ_PARTNER_AN       2
`define APS_CTRL_SOFT_RESET      0

// ----------------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------------
`define APS_RST_ABILITY          16'h0000
`define APS_RST_LOCAL_NP         1'b1
`define APS_RST_IRQ              3'h0
`define APS_RESP_OKAY            2'h0
`define APS_RESP_SLVERR          2'h2

`endif

/* hdl/autoneg_partner_status_pkg.sv */
// Purpose: types shared by the partner status register block and its bench
// Assumes: constants come from autoneg_partner_status_params.svh
// Notes:   no values live here, only layouts
package autoneg_partner_status_pkg;

  // --------------------------------------------------------------------------
  // base page ability word layout
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       partner_next_page_request;
    logic       partner_acknowledge;
    logic       partner_remote_fault;
    logic       reserved;
    logic       partner_asymmetric_pause;
    logic       partner_pause;
    logic       partner_four_pair_ability;
    logic       partner_fast_full_duplex;
    logic       partner_fast_half_duplex;
    logic       partner_ten_mbit_full_duplex;
    logic       partner_ten_mbit_half_duplex;
    logic [4:0] partner_selector;
  } ability_word_type;

  // --------------------------------------------------------------------------
  // inputs from the negotiation state machine, same clock
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic             page_valid;        // one-cycle pulse: code word received
    ability_word_type page_word;         // word that came with page_valid
    logic             an_complete;       // level: negotiation completed
    logic             partner_an_detect; // level: partner sends link pulse bursts
    logic             parallel_fault;    // level: parallel detection fault
  } an_event_type;

endpackage : autoneg_partner_status_pkg

/* verification/an_link_partner.sv */
// Purpose: behavioural negotiation source that feeds AN_EVENTS
// Assumes: driven only through its tasks, called just after a rising edge
// Notes:   pages last one cycle; levels hold until changed
`timescale 1ns/100ps
module an_link_partner (
  input  wire logic                                 SYS_CLK,
  output autoneg_partner_status_pkg::an_event_type  AN_EVENTS
);
  // idle at time zero: no page, all levels low
  initial begin
    AN_EVENTS = '0;
  end

  // one-cycle code word; afterwards the word bus shows the inverse, not the old value
  task automatic send_page(input logic [15:0] word);
    @(posedge SYS_CLK);
    AN_EVENTS.page_valid <= 1'b1;
    AN_EVENTS.page_word  <= word;
    @(posedge SYS_CLK);
    AN_EVENTS.page_valid <= 1'b0;
    AN_EVENTS.page_word  <= ~word;
  endtask : send_page

  // completion, partner detect and parallel fault levels
  task automatic set_levels(input logic complete, input logic detect, input logic fault);
    @(posedge SYS_CLK);
    AN_EVENTS.an_complete       <= complete;
    AN_EVENTS.partner_an_detect <= detect;
    AN_EVENTS.parallel_fault    <= fault;
  endtask : set_levels
endmodule : an_link_partner

/* verification/tb_top.sv */
// Purpose: self-checking bench for the partner status registers
// Assumes: AXI4-Lite master tasks on SYS_CLK, partner model on AN_EVENTS
// Notes:   table loop for page words, hand tests for the awkward cases
`timescale 1ns/100ps
`include "autoneg_partner_status_params.svh"
module tb_top;
  localparam logic [5:0] ab_idx = `APS_IDX_PARTNER_ABILITY;
  localparam logic [5:0] ex_idx = `APS_IDX_EXPANSION;
  localparam logic [5:0] st_idx = `APS_IDX_IRQ_STATUS;
  localparam logic [5:0] mk_idx = `APS_IDX_IRQ_MASK;
  localparam logic [5:0] ct_idx = `APS_IDX_CONTROL;
  localparam logic [1:0] ok     = `APS_RESP_OKAY;
  localparam logic [1:0] err    = `APS_RESP_SLVERR;
  typedef struct packed {logic [15:0] word; logic [15:0] ability; logic [15:0] exp;} row_type;

  logic        SYS_CLK = 1'b0, RST_N = 1'b0;
  logic [7:0]  S_AWADDR = 8'h00, S_ARADDR = 8'h00;
  logic [31:0] S_WDATA = 32'h0, S_RDATA;
  logic [3:0]  S_WSTRB = 4'hF;
  logic        S_AWVALID = 1'b0, S_WVALID = 1'b0, S_BREADY = 1'b0, S_ARVALID = 1'b0;
  logic        S_RREADY = 1'b0, S_AWREADY, S_WREADY, S_BVALID, S_ARREADY, S_RVALID, IRQ;
  logic [1:0]  S_BRESP, S_RRESP;
  autoneg_partner_status_pkg::an_event_type an_events;
  int          fail_count = 0, n_tests = 0, cycles = 0;
  row_type     rows [13] = '{
    '{16'h8000, 16'h8000, 16'h000E}, '{16'h4000, 16'h4000, 16'h0006},
    '{16'h2000, 16'h2000, 16'h0006}, '{16'h1000, 16'h0000, 16'h0006},
    '{16'h0800, 16'h0800, 16'h0006}, '{16'h0400, 16'h0400, 16'h0006},
    '{16'h0200, 16'h0200, 16'h0006}, '{16'h0100, 16'h0100, 16'h0006},
    '{16'h0080, 16'h0080, 16'h0006}, '{16'h0040, 16'h0040, 16'h0006},
    '{16'h0020, 16'h0020, 16'h0006}, '{16'h001F, 16'h001F, 16'h0006},
    '{16'hFFFF, 16'hEFFF, 16'h000E}};

  always #12.5 SYS_CLK = ~SYS_CLK;

  autoneg_partner_status_regs dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .S_AWADDR(S_AWADDR),
    .S_AWVALID(S_AWVALID), .S_AWREADY(S_AWREADY), .S_WDATA(S_WDATA), .S_WSTRB(S_WSTRB),
    .S_WVALID(S_WVALID), .S_WREADY(S_WREADY), .S_BRESP(S_BRESP), .S_BVALID(S_BVALID),
    .S_BREADY(S_BREADY), .S_ARADDR(S_ARADDR), .S_ARVALID(S_ARVALID), .S_ARREADY(S_ARREADY),
    .S_RDATA(S_RDATA), .S_RRESP(S_RRESP), .S_RVALID(S_RVALID), .S_RREADY(S_RREADY),
    .AN_EVENTS(an_events), .IRQ(IRQ));
  an_link_partner partner (.SYS_CLK(SYS_CLK), .AN_EVENTS(an_events));

  // ----------------------------------------------------------------------------
  // compare, bus and reset tasks
  // ----------------------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_flag

  task automatic complete_run;
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // write: address and data offered together, each released when taken
  task automatic wr_chk(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] resp);
    logic aw, w;
    @(posedge SYS_CLK);
    S_AWADDR  <= {idx, 2'b00};
    S_WDATA   <= d;
    S_AWVALID <= 1'b1;
    S_WVALID  <= 1'b1;
    S_BREADY  <= 1'b1;
    aw = 1'b1;
    w  = 1'b1;
    while (aw || w) begin
      @(posedge SYS_CLK);
      if (aw && S_AWREADY === 1'b1) begin
        aw = 1'b0;
        S_AWVALID <= 1'b0;
      end
      if (w && S_WREADY === 1'b1) begin
        w = 1'b0;
        S_WVALID <= 1'b0;
      end
    end
    do @(posedge SYS_CLK); while (S_BVALID !== 1'b1);
    S_BREADY <= 1'b0;
    chk_word({30'h0, S_BRESP}, {30'h0, resp});
  endtask : wr_chk

  // read: data and response taken at the edge where rvalid is seen
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] resp);
    @(posedge SYS_CLK);
    S_ARADDR  <= {idx, 2'b00};
    S_ARVALID <= 1'b1;
    S_RREADY  <= 1'b1;
    do @(posedge SYS_CLK); while (S_ARREADY !== 1'b1);
    S_ARVALID <= 1'b0;
    do @(posedge SYS_CLK); while (S_RVALID !== 1'b1);
    S_RREADY <= 1'b0;
    chk_word(S_RDATA, exp);
    chk_word({30'h0, S_RRESP}, {30'h0, resp});
  endtask : rd_chk

  task automatic hw_reset;
    RST_N <= 1'b0;
    repeat (16) @(posedge SYS_CLK);
    chk_flag(IRQ, 1'b0);
    RST_N <= 1'b1;
  endtask : hw_reset

  // hang guard: far above the few hundred cycles the sequence needs
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    hw_reset();
    rd_chk(ab_idx, 32'h0, ok);
    rd_chk(ex_idx, 32'h4, ok);
    for (int i = 0; i < 13; i++) begin
      partner.send_page(rows[i].word);
      rd_chk(ab_idx, {16'h0, rows[i].ability}, ok);
      rd_chk(ex_idx, {16'h0, rows[i].exp}, ok);
      rd_chk(ex_idx, {16'h0, rows[i].exp & 16'hFFFD}, ok);
    end
    // writes to read-only places change nothing; unmapped place refused
    wr_chk(ab_idx, 32'hFFFF, ok);
    rd_chk(ab_idx, 32'hEFFF, ok);
    wr_chk(ex_idx, 32'hFFFF, ok);
    rd_chk(ex_idx, 32'h000C, ok);
    wr_chk(6'h1F, 32'h1, err);
    rd_chk(6'h1F, 32'h0, err);
    // a write with byte 0 not strobed leaves the mask untouched
    S_WSTRB <= 4'h0;
    wr_chk(mk_idx, 32'h7, ok);
    S_WSTRB <= 4'hF;
    rd_chk(mk_idx, 32'h0, ok);
    // interrupt: raised, masked, cleared
    chk_flag(IRQ, 1'b0);
    wr_chk(mk_idx, 32'h7, ok);
    chk_flag(IRQ, 1'b1);
    rd_chk(st_idx, 32'h1, ok);
    wr_chk(st_idx, 32'h1, ok);
    chk_flag(IRQ, 1'b0);
    partner.set_levels(1'b0, 1'b1, 1'b1);
    rd_chk(ex_idx, 32'h001D, ok);
    rd_chk(st_idx, 32'h6, ok);
    chk_flag(IRQ, 1'b1);
    wr_chk(mk_idx, 32'h1, ok);
    chk_flag(IRQ, 1'b0);
    wr_chk(st_idx, 32'h6, ok);
    rd_chk(st_idx, 32'h0, ok);
    // page after completion loads only when the stored word asks for next pages
    partner.set_levels(1'b0, 1'b0, 1'b0);
    partner.send_page(16'h0001);
    partner.set_levels(1'b1, 1'b0, 1'b0);
    partner.send_page(16'h00A1);
    rd_chk(ab_idx, 32'h0001, ok);
    partner.set_levels(1'b0, 1'b0, 1'b0);
    partner.send_page(16'h8001);
    partner.set_levels(1'b1, 1'b0, 1'b0);
    partner.send_page(16'h0041);
    rd_chk(ab_idx, 32'h0041, ok);
    partner.set_levels(1'b0, 1'b0, 1'b0);
    // page arriving in the cycle of the clearing read keeps the flag
    fork
      partner.send_page(16'h0021);
      rd_chk(ex_idx, 32'h6, ok);
    join
    rd_chk(ex_idx, 32'h6, ok);
    rd_chk(ex_idx, 32'h4, ok);
    // soft reset clears partner ability word and page flag, keeps local ability
    partner.send_page(16'h8421);
    wr_chk(ct_idx, 32'h1, ok);
    rd_chk(ab_idx, 32'h0, ok);
    rd_chk(ex_idx, 32'h4, ok);
    rd_chk(ct_idx, 32'h0, ok);
    // second hardware reset in mid-run
    partner.send_page(16'h8421);
    wr_chk(mk_idx, 32'h7, ok);
    hw_reset();
    rd_chk(ab_idx, 32'h0, ok);
    rd_chk(ex_idx, 32'h4, ok);
    rd_chk(mk_idx, 32'h0, ok);
    complete_run();
  end
endmodule : tb_top
